// ### design/lmc_core.sv
// long mode enable, activation, consistency checks and size decode behind apb
`default_nettype none
`include "lmc_regs.svh"
module lmc_core
   import lmc_pkg::*;
(
   input  wire  logic        pclk,
   input  wire  logic        presetn,
   input  wire  logic        psel,
   input  wire  logic        penable,
   input  wire  logic        pwrite,
   input  wire  logic [11:0] paddr,
   input  wire  logic [31:0] pwdata,
   input  wire  logic [3:0]  pstrb,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   output logic              long_mode_active_flag,
   output logic              general_protection_fault,
   output logic [3:0]        submode,
   output logic [1:0]        default_addr_size,
   output logic [1:0]        default_opnd_size,
   output logic              size_override_ok
);
   lmc_state_s st;
   lmc_state_s next_st;

   logic        setup;
   logic        wr;
   logic        full_word;
   logic        chk_fail;
   logic        want_lme;
   logic        want_pg;
   logic        want_pae;
   logic [31:0] rd_word;

   // answer on the cycle after setup: no wait state, pready from a flop
   assign setup     = psel && !penable && !st.pready;
   assign wr        = setup && pwrite;
   assign full_word = (pstrb == 4'hF);

   assign want_lme = pwdata[`LMC_LME_POS];
   assign want_pg  = pwdata[`LMC_PG_POS];
   assign want_pae = pwdata[`LMC_PAE_POS];

   always_comb begin
      chk_fail = 1'b0;
      if (wr && full_word) begin
         case (paddr)
            `LMC_OFF_EXT_FEATURE: chk_fail = (want_lme != st.lme) && st.pg;
            `LMC_OFF_CTRL_ZERO:   chk_fail = want_pg && !st.pg && st.lme &&
                                             (!st.pae || st.cs_l);
            `LMC_OFF_CTRL_FOUR:   chk_fail = !want_pae && st.pae && st.lma;
            default:              chk_fail = 1'b0;
         endcase
      end
   end

   always_comb begin
      rd_word = 32'h0000_0000;
      case (paddr)
         `LMC_OFF_EXT_FEATURE: begin
            rd_word[`LMC_LME_POS] = st.lme;
            rd_word[`LMC_LMA_POS] = st.lma;
         end
         `LMC_OFF_CTRL_ZERO:   rd_word[`LMC_PG_POS]  = st.pg;
         `LMC_OFF_CTRL_FOUR:   rd_word[`LMC_PAE_POS] = st.pae;
         `LMC_OFF_PT_BASE_LO:  rd_word = st.pt_base[31:0];
         `LMC_OFF_PT_BASE_HI:  rd_word = st.pt_base[63:32];
         `LMC_OFF_CODE_SEG: begin
            rd_word[`LMC_CSL_POS] = st.cs_l;
            rd_word[`LMC_CSD_POS] = st.cs_d;
         end
         `LMC_OFF_MODE_STATUS: rd_word = {22'h000000, st.opnd_size, st.addr_size,
                                          2'h0, st.submode};
         `LMC_OFF_FAULT: begin
            rd_word[`LMC_FAULT_GP_POS] = st.gp_sticky;
            rd_word[31:`LMC_FAULT_CNT_POS] = st.gp_count;
         end
         `LMC_OFF_DESC_CTRL:   rd_word[`LMC_DESC_RELOAD_POS] = st.desc_stale;
         default:              rd_word = 32'h0000_0000;
      endcase
   end

   always_comb begin
      next_st          = st;
      next_st.pready   = setup;
      next_st.pslverr  = 1'b0;
      next_st.gp_fault = 1'b0;
      if (setup && !pwrite) begin
         next_st.prdata = rd_word;
      end
      if (setup) begin
         case (paddr)
            `LMC_OFF_EXT_FEATURE, `LMC_OFF_CTRL_ZERO, `LMC_OFF_CTRL_FOUR,
            `LMC_OFF_PT_BASE_LO, `LMC_OFF_PT_BASE_HI, `LMC_OFF_CODE_SEG,
            `LMC_OFF_MODE_STATUS, `LMC_OFF_FAULT, `LMC_OFF_DESC_CTRL:
               next_st.pslverr = pwrite && !full_word;
            default:
               next_st.pslverr = 1'b1;
         endcase
      end
      if (chk_fail) begin
         // failed write is dropped whole; only the fault is reported
         next_st.gp_fault  = 1'b1;
         next_st.gp_sticky = 1'b1;
         next_st.gp_count  = st.gp_count + 16'h0001;
      end else if (wr && full_word) begin
         case (paddr)
            `LMC_OFF_EXT_FEATURE: next_st.lme = want_lme;
            `LMC_OFF_CTRL_ZERO: begin
               next_st.pg = want_pg;
               if (want_pg && !st.pg && st.lme) begin
                  next_st.lma        = 1'b1;
                  next_st.desc_stale = 1'b1;
               end
               if (!want_pg && st.lma) begin
                  next_st.lma = 1'b0;
               end
            end
            `LMC_OFF_CTRL_FOUR:  next_st.pae = want_pae;
            // before activation only the low half of the base is writable
            `LMC_OFF_PT_BASE_LO: next_st.pt_base[31:0] = pwdata;
            `LMC_OFF_PT_BASE_HI: begin
               if (st.lma) begin
                  next_st.pt_base[63:32] = pwdata;
               end
            end
            `LMC_OFF_CODE_SEG: begin
               next_st.cs_l = pwdata[`LMC_CSL_POS];
               next_st.cs_d = pwdata[`LMC_CSD_POS];
            end
            // write one clears the sticky fault flag; the count and the stale marker are kept
            `LMC_OFF_FAULT: begin
               if (pwdata[`LMC_FAULT_GP_POS]) begin
                  next_st.gp_sticky = 1'b0;
               end
            end
            `LMC_OFF_DESC_CTRL: begin
               if (pwdata[`LMC_DESC_RELOAD_POS] && !next_st.lma) begin
                  next_st.desc_stale = 1'b0;
               end else if (pwdata[`LMC_DESC_RELOAD_POS] && st.desc_stale) begin
                  next_st.desc_stale = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      // decode follows the next-state control bits, so it changes in the same cycle as they do
      if (!next_st.lma) begin
         next_st.submode = LMC_SUB_LEGACY;
      end else if (!next_st.cs_l) begin
         next_st.submode = LMC_SUB_COMPAT;
      end else if (!next_st.cs_d) begin
         next_st.submode = LMC_SUB_LONG64;
      end else begin
         next_st.submode = LMC_SUB_RESERVED;
      end
      case (next_st.submode)
         LMC_SUB_LONG64: begin
            next_st.addr_size = LMC_SZ_64;
            next_st.opnd_size = LMC_SZ_32;
         end
         LMC_SUB_LEGACY, LMC_SUB_COMPAT: begin
            next_st.addr_size = next_st.cs_d ? LMC_SZ_32 : LMC_SZ_16;
            next_st.opnd_size = next_st.cs_d ? LMC_SZ_32 : LMC_SZ_16;
         end
         default: begin
            next_st.addr_size = LMC_SZ_32;
            next_st.opnd_size = LMC_SZ_32;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st            <= '0;
         st.submode    <= LMC_SUB_LEGACY;
         st.addr_size  <= LMC_SZ_16;
         st.opnd_size  <= LMC_SZ_16;
      end else begin
         st <= next_st;
      end
   end

   assign prdata                   = st.prdata;
   assign pready                   = st.pready;
   assign pslverr                  = st.pslverr;
   assign long_mode_active_flag    = st.lma;
   assign general_protection_fault = st.gp_fault;
   assign submode                  = st.submode;
   assign default_addr_size        = st.addr_size;
   assign default_opnd_size        = st.opnd_size;
   // one-hot code: the 64-bit bit of the submode flop drives the pin directly
   assign size_override_ok         = st.submode[2];

   a_lma_needs_pg: assert property (@(posedge pclk) disable iff (!presetn)
      st.lma |-> st.pg && st.lme)
      else $error("active flag without paging and enable");
   a_legacy_sizes: assert property (@(posedge pclk) disable iff (!presetn)
      !st.lma |-> st.addr_size != LMC_SZ_64 && st.opnd_size != LMC_SZ_64)
      else $error("64-bit size while not active");
   a_sub64_decode: assert property (@(posedge pclk) disable iff (!presetn)
      (st.lma && st.cs_l && !st.cs_d) |-> (st.addr_size == LMC_SZ_64 &&
      st.opnd_size == LMC_SZ_32 && size_override_ok))
      else $error("64-bit submode sizes wrong");
   a_reserved_enc: assert property (@(posedge pclk) disable iff (!presetn)
      (st.lma && st.cs_l && st.cs_d) |-> st.submode == LMC_SUB_RESERVED)
      else $error("reserved encoding given a submode");
   a_compat_sizes: assert property (@(posedge pclk) disable iff (!presetn)
      (!st.lma || !st.cs_l) |-> (st.opnd_size == (st.cs_d ? LMC_SZ_32 : LMC_SZ_16)))
      else $error("compat or legacy size wrong");
   a_lme_pg_gp: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && full_word && paddr == `LMC_OFF_EXT_FEATURE && st.pg && want_lme != st.lme)
      |=> general_protection_fault && $stable(st.lme))
      else $error("enable change under paging not faulted");
   a_pg_chk_gp: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && full_word && paddr == `LMC_OFF_CTRL_ZERO && want_pg && !st.pg && st.lme &&
      (!st.pae || st.cs_l)) |=> general_protection_fault && !st.pg && !st.lma)
      else $error("paging enable check not faulted");
   a_pae_clr_gp: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && full_word && paddr == `LMC_OFF_CTRL_FOUR && !want_pae && st.lma)
      |=> general_protection_fault && st.pae)
      else $error("extension clear while active not faulted");
   a_pg_off_lma: assert property (@(posedge pclk) disable iff (!presetn)
      (st.lma && !st.pg) |-> 1'b0)
      else $error("active flag kept after paging off");
   a_hi_base_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !st.lma ##1 !st.lma |-> $stable(st.pt_base[63:32]))
      else $error("base high half written before active");

   a_gp_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
      general_protection_fault |=> !general_protection_fault)
      else $error("fault pulse longer than one cycle");

   a_gp_on_fail: assert property (@(posedge pclk) disable iff (!presetn)
      chk_fail |=> general_protection_fault)
      else $error("failed check gave no fault pulse");

   a_gp_no_err: assert property (@(posedge pclk) disable iff (!presetn)
      general_protection_fault |-> pready && !pslverr)
      else $error("fault pulse outside a clean bus answer");

   a_fail_keeps_bits: assert property (@(posedge pclk) disable iff (!presetn)
      chk_fail |=> $stable(st.lme) && $stable(st.pg) && $stable(st.pae) && $stable(st.lma))
      else $error("failed write changed a mode bit");

   a_lme_hold_pg: assert property (@(posedge pclk) disable iff (!presetn)
      st.pg |=> $stable(st.lme))
      else $error("enable bit moved while paging on");

   a_pg_on_pae: assert property (@(posedge pclk) disable iff (!presetn)
      ($rose(st.pg) && st.lme) |-> st.pae)
      else $error("paging enabled with enable set and extension clear");

   a_pg_on_cs_long: assert property (@(posedge pclk) disable iff (!presetn)
      ($rose(st.pg) && st.lme) |-> !st.cs_l)
      else $error("paging enabled with enable and long attribute set");

   a_lma_rise_pg: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(st.lma) |-> $rose(st.pg) && st.lme)
      else $error("active flag rose without paging enable");

   a_pg_sets_lma: assert property (@(posedge pclk) disable iff (!presetn)
      ($rose(st.pg) && st.lme) |-> st.lma)
      else $error("paging enable with enable set did not activate");

   a_pae_kept: assert property (@(posedge pclk) disable iff (!presetn)
      st.lma |-> st.pae)
      else $error("active without address extension");

   a_desc_stale_act: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(st.lma) |-> st.desc_stale)
      else $error("activation did not flag legacy descriptor tables");

   a_override_64: assert property (@(posedge pclk) disable iff (!presetn)
      size_override_ok == (st.submode == LMC_SUB_LONG64))
      else $error("override permission outside 64-bit submode");

   a_submode_onehot: assert property (@(posedge pclk) disable iff (!presetn)
      $onehot(st.submode))
      else $error("submode not one-hot");

   a_pg_off_clears: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && full_word && paddr == `LMC_OFF_CTRL_ZERO && !want_pg && st.lma)
      |=> !st.lma)
      else $error("paging off kept active flag");

   a_lo_base_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && full_word && paddr == `LMC_OFF_PT_BASE_LO)
      |=> st.pt_base[31:0] == $past(pwdata))
      else $error("base low half not written");

   a_hi_base_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && full_word && paddr == `LMC_OFF_PT_BASE_HI && st.lma)
      |=> st.pt_base[63:32] == $past(pwdata))
      else $error("base high half not written while active");

   a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      setup |=> pready ##1 !pready)
      else $error("bus answer not a single cycle after setup");

   a_strobe_refused: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && pwrite && !full_word)
      |=> pslverr && $stable(st.lme) && $stable(st.pg) && $stable(st.pae))
      else $error("partial write not refused");
endmodule : lmc_core
`default_nettype wire

// ### design/lmc_regs.svh
// register offsets, fields and reset values of the long mode control block
`ifndef LMC_REGS_SVH
`define LMC_REGS_SVH
`define LMC_OFF_EXT_FEATURE   12'h000
`define LMC_OFF_CTRL_ZERO     12'h004
`define LMC_OFF_CTRL_FOUR     12'h008
`define LMC_OFF_PT_BASE_LO    12'h00C
`define LMC_OFF_PT_BASE_HI    12'h010
`define LMC_OFF_CODE_SEG      12'h014
`define LMC_OFF_MODE_STATUS   12'h018
`define LMC_OFF_FAULT         12'h01C
`define LMC_OFF_DESC_CTRL     12'h020
`define LMC_LME_POS           8
`define LMC_LMA_POS           10
`define LMC_PG_POS            31
`define LMC_PAE_POS           5
`define LMC_CSL_POS           0
`define LMC_CSD_POS           1
`define LMC_DESC_RELOAD_POS   0
`define LMC_FAULT_GP_POS      0
`define LMC_FAULT_CNT_POS     16
`define LMC_RST_WORD          32'h0000_0000
`endif

// ### design/lmc_pkg.sv
// types shared by the long mode control block
`default_nettype none
package lmc_pkg;
   typedef enum logic [3:0] {
      LMC_SUB_LEGACY   = 4'h1,
      LMC_SUB_COMPAT   = 4'h2,
      LMC_SUB_LONG64   = 4'h4,
      LMC_SUB_RESERVED = 4'h8
   } lmc_submode_e;

   typedef enum logic [1:0] {
      LMC_SZ_16 = 2'h0,
      LMC_SZ_32 = 2'h1,
      LMC_SZ_64 = 2'h2
   } lmc_size_e;

   typedef struct packed {
      logic               lme;
      logic               lma;
      logic               pg;
      logic               pae;
      logic [63:0]        pt_base;
      logic               cs_l;
      logic               cs_d;
      logic               gp_sticky;
      logic [15:0]        gp_count;
      logic               gp_fault;
      logic               desc_stale;
      lmc_submode_e       submode;
      lmc_size_e          addr_size;
      lmc_size_e          opnd_size;
      logic               pready;
      logic               pslverr;
      logic [31:0]        prdata;
   } lmc_state_s;
endpackage : lmc_pkg
`default_nettype wire

// ### tb/tb_long_mode_control.sv
// self-checking bench of the long mode control block over apb
`default_nettype none
`include "lmc_regs.svh"
module tb_long_mode_control
   import lmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, lma, gp, ovr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, rs, v;
   logic [3:0]  pstrb, sub;
   logic [1:0]  asz, osz;
   int          n_mismatch, checked, n_gp, cyc;

   lmc_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .long_mode_active_flag(lma),
      .general_protection_fault(gp), .submode(sub), .default_addr_size(asz),
      .default_opnd_size(osz), .size_override_ok(ovr));

   initial pclk = 1'b0;
   always #12.5 pclk = ~pclk;

   // fault pulses counted here so a one-cycle pulse is never missed
   always @(posedge pclk) begin
      cyc++;
      if (gp === 1'b1) n_gp++;
      if (cyc == 3000) begin
         n_mismatch++;
         results();
      end
   end

   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction : xs

   function automatic logic [3:0] exp_sub(input logic act, input logic l, input logic d);
      return !act ? LMC_SUB_LEGACY : (!l ? LMC_SUB_COMPAT : (d ? LMC_SUB_RESERVED : LMC_SUB_LONG64));
   endfunction : exp_sub

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // request held until pready is sampled high, then released
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // only the bench timeout ends a wait that never gets an answer
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic f);
      int g0;
      g0 = n_gp;
      apb(1'b1, a, d);
      chk("fault pulses", 32'(f), 32'(n_gp - g0));
   endtask : wr

   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk("read data", e, rd);
   endtask : rdc

   task automatic dchk(input logic act, input logic l, input logic d);
      logic [3:0] es;
      logic [1:0] ez;
      es = exp_sub(act, l, d);
      ez = d ? LMC_SZ_32 : LMC_SZ_16;
      chk("active flag", 32'(act), 32'(lma));
      chk("submode", 32'(es), 32'(sub));
      chk("override", 32'(es == LMC_SUB_LONG64), 32'(ovr));
      if (es == LMC_SUB_LONG64) begin
         chk("addr size", 32'(LMC_SZ_64), 32'(asz));
         chk("opnd size", 32'(LMC_SZ_32), 32'(osz));
      end else if (es != LMC_SUB_RESERVED) begin
         chk("addr size", 32'(ez), 32'(asz));
         chk("opnd size", 32'(ez), 32'(osz));
      end
   endtask : dchk

   task automatic results();
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite} = 3'h0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'hF;
      rs = 32'h0000_002C;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      dchk(1'b0, 1'b0, 1'b0);
      rdc(`LMC_OFF_EXT_FEATURE, 32'h0000_0000);
      // long attribute has no effect before activation
      wr(`LMC_OFF_CODE_SEG, 32'h0000_0003, 1'b0);
      dchk(1'b0, 1'b1, 1'b1);
      wr(`LMC_OFF_CODE_SEG, 32'h0000_0001, 1'b0);
      wr(`LMC_OFF_EXT_FEATURE, 32'h0000_0100, 1'b0);
      dchk(1'b0, 1'b1, 1'b0);
      wr(`LMC_OFF_PT_BASE_LO, 32'hA5A5_F000, 1'b0);
      wr(`LMC_OFF_PT_BASE_HI, 32'h0000_1234, 1'b0);
      rdc(`LMC_OFF_PT_BASE_HI, 32'h0000_0000);
      rdc(`LMC_OFF_PT_BASE_LO, 32'hA5A5_F000);
      wr(`LMC_OFF_CTRL_ZERO, 32'h8000_0000, 1'b1);
      rdc(`LMC_OFF_CTRL_ZERO, 32'h0000_0000);
      wr(`LMC_OFF_CTRL_FOUR, 32'h0000_0020, 1'b0);
      wr(`LMC_OFF_CTRL_ZERO, 32'h8000_0000, 1'b1);
      chk("active flag", 32'h0, 32'(lma));
      wr(`LMC_OFF_CODE_SEG, 32'h0000_0000, 1'b0);
      rdc(`LMC_OFF_DESC_CTRL, 32'h0000_0000);
      wr(`LMC_OFF_CTRL_ZERO, 32'h8000_0000, 1'b0);
      dchk(1'b1, 1'b0, 1'b0);
      rdc(`LMC_OFF_MODE_STATUS, 32'h0000_0002);
      rdc(`LMC_OFF_EXT_FEATURE, 32'h0000_0500);
      rdc(`LMC_OFF_DESC_CTRL, 32'h0000_0001);
      wr(`LMC_OFF_PT_BASE_HI, 32'h0000_1234, 1'b0);
      rdc(`LMC_OFF_PT_BASE_HI, 32'h0000_1234);
      wr(`LMC_OFF_DESC_CTRL, 32'h0000_0001, 1'b0);
      rdc(`LMC_OFF_DESC_CTRL, 32'h0000_0000);
      $display("test activation done");
      wr(`LMC_OFF_EXT_FEATURE, 32'h0000_0000, 1'b1);
      rdc(`LMC_OFF_EXT_FEATURE, 32'h0000_0500);
      wr(`LMC_OFF_CTRL_FOUR, 32'h0000_0000, 1'b1);
      rdc(`LMC_OFF_CTRL_FOUR, 32'h0000_0020);
      $display("test consistency faults done");
      for (int i = 0; i < 24; i++) begin
         v = xs();
         wr(`LMC_OFF_CODE_SEG, {30'h0, v[1:0]}, 1'b0);
         dchk(1'b1, v[0], v[1]);
      end
      wr(`LMC_OFF_CTRL_ZERO, 32'h0000_0000, 1'b0);
      dchk(1'b0, v[0], v[1]);
      wr(`LMC_OFF_EXT_FEATURE, 32'h0000_0000, 1'b0);
      for (int i = 0; i < 8; i++) begin
         v = xs();
         wr(`LMC_OFF_CODE_SEG, {30'h0, v[1:0]}, 1'b0);
         dchk(1'b0, v[0], v[1]);
      end
      $display("test submode decode done");
      apb(1'b1, 12'h024, 32'h0000_0100);
      chk("unmapped error", 32'h1, 32'(err));
      pstrb <= 4'h3;
      apb(1'b1, `LMC_OFF_EXT_FEATURE, 32'h0000_0100);
      chk("strobe error", 32'h1, 32'(err));
      pstrb <= 4'hF;
      rdc(`LMC_OFF_EXT_FEATURE, 32'h0000_0000);
      // four faulted control writes above, sticky bit and count
      rdc(`LMC_OFF_FAULT, 32'h0004_0001);
      $display("test refusals done");
      results();
   end
endmodule : tb_long_mode_control
`default_nettype wire
